// file: hw/hbu_top.v
/*
  hardware breakpoint unit: APB registers, address/data compare against
  the cpu bus, software interrupt or debug entry requests.
  assumes cpu bus inputs come from logic on core_clk_in (no sync needed),
  while debug-active and debug-enable flags arrive from the debug unit
  on the same clock.
*/
// Function
// - two mode bits choose off, dual interrupt, full debug, dual debug
// - no match at all while background debug mode is active
// - dual interrupt mode: each executed address hit raises software interrupt, fetch only
// - dual interrupt mode ignores all read/write compare bits
// - dual modes: data compare enable arms second breakpoint; size bit unused
// - debug entry requested only when debug unit reports debug enabled
// - dual debug mode: each breakpoint qualified by fetch, range, read/write
// - fetch-only break fires only on executed instruction via tag
// - range 0 clear: high byte only; set: full address for first
// - dual modes: range 1 set adds low byte for second breakpoint
// - compare enable clear: data compare registers never used
// - full mode: mask high excludes data bits 15:8
// - full mode: mask low excludes data bits 7:0
// - first breakpoint read/write don't-care or write/read select
// - second breakpoint read/write select, unused in full mode
// - compare registers match data in full mode, address in dual modes
// - address high always compared; low only when range 0 set
// - both control registers accessible anytime; control 1 bit 7 reads zero
// - tag travels with fetch; debug entered when it reaches queue head and executes
`timescale 1ns/100ps
`include "hbu_map.vh"
module hbu_top #(
  parameter AW = 16,
  parameter DW = 16
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`HBU_ADDR_W+1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire [AW-1:0] cpu_addr_in,
  input wire [DW-1:0] cpu_data_in,
  input wire cpu_rw_in,
  input wire cpu_valid_in,
  input wire cpu_fetch_in,
  input wire queue_head_in,
  input wire queue_head_exec_in,
  input wire insn_boundary_in,
  input wire debug_active_in,
  input wire debug_enable_in,
  output reg swi_req_out,
  output reg debug_req_out,
  output reg fetch_tag_out
);
  reg [7:0] ctrl0_r;
  reg [7:0] ctrl1_r;
  reg [7:0] ahi_r;
  reg [7:0] alo_r;
  reg [7:0] chi_r;
  reg [7:0] clo_r;
  reg [1:0] hit_r;
  reg pend_r;
  reg tag_pend_r;
  reg [31:0] rdata_nxt;
  reg map_hit;
  wire [`HBU_ADDR_W-1:0] idx = paddr_in[`HBU_ADDR_W+1:2];
  wire wr_en = psel_in & penable_in & pwrite_in;
  // single-cycle access phase: slave is always ready
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~map_hit;

  always @* begin
    rdata_nxt = 32'h0000_0000;
    map_hit = 1'b1;
    if (idx == `HBU_CTRL0_IDX) begin
      rdata_nxt[7:0] = ctrl0_r & `HBU_C0_WMASK;
    end else if (idx == `HBU_CTRL1_IDX) begin
      rdata_nxt[7:0] = ctrl1_r & `HBU_C1_WMASK;
    end else if (idx == `HBU_AHI_IDX) begin
      rdata_nxt[7:0] = ahi_r;
    end else if (idx == `HBU_ALO_IDX) begin
      rdata_nxt[7:0] = alo_r;
    end else if (idx == `HBU_CHI_IDX) begin
      rdata_nxt[7:0] = chi_r;
    end else if (idx == `HBU_CLO_IDX) begin
      rdata_nxt[7:0] = clo_r;
    end else if (idx == `HBU_STAT_IDX) begin
      rdata_nxt[3:0] = {tag_pend_r, pend_r, hit_r};
    end else begin
      map_hit = 1'b0;
    end
  end

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl0_r <= `HBU_REG_RST;
      ctrl1_r <= `HBU_REG_RST;
      ahi_r <= `HBU_REG_RST;
      alo_r <= `HBU_REG_RST;
      chi_r <= `HBU_REG_RST;
      clo_r <= `HBU_REG_RST;
      prdata_out <= 32'h0000_0000;
    end else begin
      if (psel_in & ~penable_in & ~pwrite_in) begin
        prdata_out <= rdata_nxt;
      end
      if (wr_en) begin
        // writable in every mode, no lockout
        if (idx == `HBU_CTRL0_IDX) begin
          ctrl0_r <= pwdata_in[7:0] & `HBU_C0_WMASK;
        end else if (idx == `HBU_CTRL1_IDX) begin
          ctrl1_r <= pwdata_in[7:0] & `HBU_C1_WMASK;
        end else if (idx == `HBU_AHI_IDX) begin
          ahi_r <= pwdata_in[7:0];
        end else if (idx == `HBU_ALO_IDX) begin
          alo_r <= pwdata_in[7:0];
        end else if (idx == `HBU_CHI_IDX) begin
          chi_r <= pwdata_in[7:0];
        end else if (idx == `HBU_CLO_IDX) begin
          clo_r <= pwdata_in[7:0];
        end
      end
    end
  end

  wire [1:0] mode = {ctrl0_r[`HBU_C0_MODE_HI], ctrl0_r[`HBU_C0_MODE_LO]};
  wire mode_swi = (mode == `HBU_MODE_SWI);
  wire mode_full = (mode == `HBU_MODE_FULL);
  wire mode_dbg = (mode == `HBU_MODE_DBG);
  wire mode_dual = mode_swi | mode_dbg;
  wire dce = ctrl1_r[`HBU_C1_DCE];
  // swi mode performs program breaks only
  wire prog_only = ctrl0_r[`HBU_C0_PROG] | mode_swi;

  // first breakpoint: address high always, low under range 0
  wire b0_hi;
  wire b0_lo;
  hbu_byte_cmp #(.W(8)) u_b0_hi (
    .a_in(cpu_addr_in[AW-1:AW-8]),
    .b_in(ahi_r),
    .care_in(1'b1),
    .hit_out(b0_hi)
  );
  hbu_byte_cmp #(.W(8)) u_b0_lo (
    .a_in(cpu_addr_in[7:0]),
    .b_in(alo_r),
    .care_in(ctrl0_r[`HBU_C0_RANGE0]),
    .hit_out(b0_lo)
  );

  // compare registers: data bus in full mode, address bus in dual modes
  wire [7:0] c_hi_src = mode_full ? cpu_data_in[DW-1:DW-8] : cpu_addr_in[AW-1:AW-8];
  wire [7:0] c_lo_src = mode_full ? cpu_data_in[7:0] : cpu_addr_in[7:0];
  wire c_hi_care = dce & (mode_dual | ~ctrl1_r[`HBU_C1_MASKH]);
  wire c_lo_care = dce & (mode_dual ? ctrl0_r[`HBU_C0_RANGE1]
                                     : ~ctrl1_r[`HBU_C1_MASKL]);
  wire c_hi;
  wire c_lo;
  hbu_byte_cmp #(.W(8)) u_c_hi (
    .a_in(c_hi_src),
    .b_in(chi_r),
    .care_in(c_hi_care),
    .hit_out(c_hi)
  );
  hbu_byte_cmp #(.W(8)) u_c_lo (
    .a_in(c_lo_src),
    .b_in(clo_r),
    .care_in(c_lo_care),
    .hit_out(c_lo)
  );

  wire rw0_ok;
  wire rw1_ok;
  hbu_rw_qual u_rw0 (
    .enable_in(ctrl1_r[`HBU_C1_RWE0] & ~mode_swi),
    .value_in(ctrl1_r[`HBU_C1_RWV0]),
    .rw_in(cpu_rw_in),
    .ok_out(rw0_ok)
  );
  hbu_rw_qual u_rw1 (
    .enable_in(ctrl1_r[`HBU_C1_RWE1] & mode_dbg),
    .value_in(ctrl1_r[`HBU_C1_RWV1]),
    .rw_in(cpu_rw_in),
    .ok_out(rw1_ok)
  );

  // all enabled fields in the same cycle; size bit never consulted
  wire cyc_ok = cpu_valid_in & ~debug_active_in & (mode != `HBU_MODE_OFF);
  wire fetch_ok = ~prog_only | cpu_fetch_in;
  wire m0 = cyc_ok & fetch_ok & b0_hi & b0_lo & rw0_ok & (mode_full ? (c_hi & c_lo) : 1'b1);
  wire m1 = cyc_ok & fetch_ok & mode_dual & dce & c_hi & c_lo & rw1_ok;
  wire any_hit = m0 | m1;

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hit_r <= 2'h0;
      pend_r <= 1'b0;
      tag_pend_r <= 1'b0;
      swi_req_out <= 1'b0;
      debug_req_out <= 1'b0;
      fetch_tag_out <= 1'b0;
    end else begin
      hit_r <= {m1, m0};
      fetch_tag_out <= any_hit & prog_only;
      swi_req_out <= 1'b0;
      debug_req_out <= 1'b0;
      if (debug_active_in) begin
        pend_r <= 1'b0;
        tag_pend_r <= 1'b0;
      end else begin
        // untagged match waits for the next instruction boundary
        if (any_hit & ~prog_only) begin
          pend_r <= 1'b1;
        end else if (pend_r & insn_boundary_in) begin
          pend_r <= 1'b0;
        end
        // tagged fetch: act when it reaches queue head and executes
        if (any_hit & prog_only) begin
          tag_pend_r <= 1'b1;
        end else if (tag_pend_r & queue_head_in) begin
          tag_pend_r <= 1'b0;
        end
        if ((pend_r & insn_boundary_in) | (tag_pend_r & queue_head_in & queue_head_exec_in)) begin
          swi_req_out <= mode_swi;
          debug_req_out <= (mode_full | mode_dbg) & debug_enable_in;
        end
      end
    end
  end
endmodule

// file: hw/hbu_map.vh
/*
  register offsets, field positions, mode codes and reset values of the
  breakpoint unit. assumes byte-addressed APB with one register per word.
*/
`ifndef HBU_MAP_VH
`define HBU_MAP_VH
`define HBU_ADDR_W 12
`define HBU_CTRL0_IDX 12'h020
`define HBU_CTRL1_IDX 12'h021
`define HBU_AHI_IDX 12'h022
`define HBU_ALO_IDX 12'h023
`define HBU_CHI_IDX 12'h024
`define HBU_CLO_IDX 12'h025
`define HBU_STAT_IDX 12'h026
`define HBU_REG_RST 8'h00
`define HBU_C0_MODE_HI 7
`define HBU_C0_MODE_LO 6
`define HBU_C0_PROG 5
`define HBU_C0_RANGE1 1
`define HBU_C0_RANGE0 0
`define HBU_C0_WMASK 8'hE3
`define HBU_C1_WMASK 8'h7F
`define HBU_C1_DCE 6
`define HBU_C1_MASKH 5
`define HBU_C1_MASKL 4
`define HBU_C1_RWE1 3
`define HBU_C1_RWV1 2
`define HBU_C1_RWE0 1
`define HBU_C1_RWV0 0
`define HBU_MODE_OFF 2'h0
`define HBU_MODE_SWI 2'h1
`define HBU_MODE_FULL 2'h2
`define HBU_MODE_DBG 2'h3
`endif

// file: hw/hbu_byte_cmp.v
/*
  one byte comparator with a care enable.
  assumes both operands are stable in the same cycle.
*/
`timescale 1ns/100ps
module hbu_byte_cmp #(
  parameter W = 8
) (
  input wire [W-1:0] a_in,
  input wire [W-1:0] b_in,
  input wire care_in,
  output wire hit_out
);
  // a byte that is not cared about always agrees
  assign hit_out = ~care_in | (a_in == b_in);
endmodule

// file: hw/hbu_rw_qual.v
/*
  read/write qualifier for one breakpoint.
  assumes rw_in is high for a read cycle, low for a write.
*/
`timescale 1ns/100ps
module hbu_rw_qual (
  input wire enable_in,
  input wire value_in,
  input wire rw_in,
  output wire ok_out
);
  assign ok_out = ~enable_in | (value_in == rw_in);
endmodule

// file: verification/hbu_cpu_model.sv
/* cpu bus model: one bus cycle per go pulse. assumes the bench pulses go_in after an edge. */
`timescale 1ns/100ps
module hbu_cpu_model (
  input wire clk_in,
  input wire go_in,
  input wire [15:0] a_in,
  input wire [15:0] d_in,
  input wire rw_in,
  input wire f_in,
  output reg valid_out = 1'b0,
  output reg [15:0] addr_out = 16'h0000,
  output reg [15:0] data_out = 16'h0000,
  output reg rw_out = 1'b0,
  output reg fetch_out = 1'b0
);
  // idle bus shows inverted values so a stale cycle can never match
  always @(posedge clk_in) begin
    valid_out <= go_in;
    addr_out <= go_in ? a_in : ~addr_out;
    data_out <= go_in ? d_in : ~data_out;
    rw_out <= go_in ? rw_in : ~rw_out;
    fetch_out <= go_in & f_in;
  end
endmodule

// file: verification/hbu_monitor.sv
/* checker on hbu_top ports. assumes one clock and async low reset. */
`timescale 1ns/100ps
`include "hbu_map.vh"
module hbu_monitor (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`HBU_ADDR_W+1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire cpu_valid_in,
  input wire cpu_fetch_in,
  input wire queue_head_in,
  input wire queue_head_exec_in,
  input wire insn_boundary_in,
  input wire debug_active_in,
  input wire debug_enable_in,
  input wire swi_req_out,
  input wire debug_req_out,
  input wire fetch_tag_out
);
  reg [1:0] mode_r;
  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence acc_s;
    psel_in && penable_in;
  endsequence
  sequence exec_s;
    queue_head_in && queue_head_exec_in;
  endsequence
  // shadow of the mode field; requests are tied to it
  always @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
      mode_r <= 2'h0;
    else if (psel_in && penable_in && pwrite_in && paddr_in == {`HBU_CTRL0_IDX, 2'b00})
      mode_r <= pwdata_in[7:6];
  rdy_const_a: assert property (pready_out)
    else $error("pready low");
  err_phase_a: assert property (pslverr_out |-> acc_s)
    else $error("pslverr outside access");
  rd_upper_a: assert property (prdata_out[31:8] == 24'h000000)
    else $error("read upper bits set");
  swi_mode_a: assert property (swi_req_out |-> mode_r == `HBU_MODE_SWI)
    else $error("swi in wrong mode");
  dbg_mode_a: assert property (debug_req_out |-> mode_r[1])
    else $error("debug request in wrong mode");
  swi_exec_a: assert property (swi_req_out |-> $past(queue_head_in && queue_head_exec_in))
    else $error("swi without executed tag");
  dbg_cause_a: assert property (debug_req_out |->
    $past(insn_boundary_in || queue_head_in && queue_head_exec_in))
    else $error("debug request without cause");
  dbg_enable_a: assert property (debug_req_out |-> $past(debug_enable_in))
    else $error("debug request while disabled");
  tag_fetch_a: assert property (fetch_tag_out |->
    $past(cpu_valid_in && cpu_fetch_in && !debug_active_in))
    else $error("tag without fetch");
  off_quiet_a: assert property ($past(mode_r) == `HBU_MODE_OFF |-> !fetch_tag_out)
    else $error("tag while off");
  cover property (exec_s ##1 swi_req_out);
endmodule
bind hbu_top hbu_monitor u_mon (.core_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .cpu_valid_in, .cpu_fetch_in,
  .queue_head_in, .queue_head_exec_in, .insn_boundary_in, .debug_active_in, .debug_enable_in,
  .swi_req_out, .debug_req_out, .fetch_tag_out);

// file: verification/tb_hardware_breakpoint_unit.sv
/* bench: apb registers and breakpoint cases. assumes hbu_top and the cpu model. */
`timescale 1ns/100ps
`include "hbu_map.vh"
module tb_hardware_breakpoint_unit;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, go = 0, rw = 0, f = 0;
  logic bnd = 0, qh = 0, qx = 0, act = 0, en = 0, probe = 0, rdy, err, cv, crw, cf, software_interrupt, dbg, tag;
  logic [13:0] pa = 14'h0000;
  logic [31:0] pwd = 32'h00000000, prd;
  logic [15:0] a = 16'h0000, d = 16'h0000, ca, cd;
  logic [16:0] seed = 17'h13A40;
  logic [32:0] rq[$];
  logic [2:0] bq[$];
  logic tag_seen = 1'b0;
  int mismatches = 0, tests_run = 0;
  initial forever #4 clk = ~clk;
  hbu_top dut (.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .cpu_addr_in(ca), .cpu_data_in(cd), .cpu_rw_in(crw), .cpu_valid_in(cv),
    .cpu_fetch_in(cf), .queue_head_in(qh), .queue_head_exec_in(qx), .insn_boundary_in(bnd),
    .debug_active_in(act), .debug_enable_in(en), .swi_req_out(software_interrupt), .debug_req_out(dbg),
    .fetch_tag_out(tag));
  hbu_cpu_model cpu (.clk_in(clk), .go_in(go), .a_in(a), .d_in(d), .rw_in(rw), .f_in(f),
    .valid_out(cv), .addr_out(ca), .data_out(cd), .rw_out(crw), .fetch_out(cf));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic stop_test();
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  always @(posedge clk) begin
    if (psel && pen && rdy && !pwr)
      cmp({err, prd}, rq.pop_front());
    // the fetch tag pulses long before the request, so it is latched until the probe
    tag_seen <= probe ? 1'b0 : (tag_seen | tag);
    if (probe)
      cmp({30'h00000000, software_interrupt, dbg, tag_seen}, {30'h00000000, bq.pop_front()});
  end
  task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= {i, 2'b00};
    pwd <= {24'h000000, v};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) begin
      mismatches++;
      stop_test();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // one cpu cycle, then a boundary (k=0) or queue head with (k=1) or without (k=2) execute
  task automatic t(input logic [15:0] aa, dd, input logic r, ff, input logic [1:0] k, e);
    a <= aa;
    d <= dd;
    rw <= r;
    f <= ff;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    bnd <= (k == 2'd0);
    qh <= (k != 2'd0);
    qx <= (k == 2'd1);
    @(posedge clk);
    bnd <= 1'b0;
    qh <= 1'b0;
    qx <= 1'b0;
    bq.push_back({e, k != 2'd0});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rq.push_back(33'h000000000);
      apb(1'b0, 12'(`HBU_CTRL0_IDX + i), 8'h00);
    end
    apb(1'b1, `HBU_CTRL1_IDX, 8'hFF);
    rq.push_back(33'h00000007F);
    apb(1'b0, `HBU_CTRL1_IDX, 8'h00);
    rq.push_back(33'h100000000);
    apb(1'b0, 12'h030, 8'h00);
    $display("registers done");
    en <= 1'b1;
    apb(1'b1, `HBU_AHI_IDX, 8'h12);
    apb(1'b1, `HBU_ALO_IDX, 8'h34);
    apb(1'b1, `HBU_CLO_IDX, 8'h56);
    apb(1'b1, `HBU_CTRL1_IDX, 8'h63);
    apb(1'b1, `HBU_CTRL0_IDX, 8'h81);
    repeat (3) begin
      seed = lfsr(seed);
      t(16'h1234, {seed[7:0], 8'h56}, 1, 0, 0, 2'b01);
    end
    t(16'h1234, 16'h0056, 0, 0, 0, 2'b00);
    t(16'h1234, 16'h0057, 1, 0, 0, 2'b00);
    t(16'h1235, 16'h0056, 1, 0, 0, 2'b00);
    apb(1'b1, `HBU_CTRL0_IDX, 8'h80);
    t(16'h12FF, 16'h0056, 1, 0, 0, 2'b01);
    apb(1'b1, `HBU_CTRL1_IDX, 8'h03);
    t(16'h12AB, 16'hFFFF, 1, 0, 0, 2'b01);
    $display("full mode done");
    apb(1'b1, `HBU_CTRL0_IDX, 8'h41);
    apb(1'b1, `HBU_CTRL1_IDX, 8'h42);
    apb(1'b1, `HBU_CHI_IDX, 8'h56);
    t(16'h1234, 16'h0000, 1, 1, 1, 2'b10);
    t(16'h56AB, 16'h0000, 1, 1, 1, 2'b10);
    t(16'h1234, 16'h0000, 1, 1, 2, 2'b00);
    $display("swi mode done");
    apb(1'b1, `HBU_CTRL0_IDX, 8'hC0);
    apb(1'b1, `HBU_CTRL1_IDX, 8'h4C);
    t(16'h56AB, 16'h0000, 0, 0, 0, 2'b00);
    t(16'h56AB, 16'h0000, 1, 0, 0, 2'b01);
    apb(1'b1, `HBU_CTRL1_IDX, 8'h0C);
    t(16'h56AB, 16'h0000, 1, 0, 0, 2'b00);
    apb(1'b1, `HBU_CTRL1_IDX, 8'h40);
    apb(1'b1, `HBU_CTRL0_IDX, 8'hC2);
    t(16'h56AB, 16'h0000, 1, 0, 0, 2'b00);
    t(16'h5656, 16'h0000, 1, 0, 0, 2'b01);
    apb(1'b1, `HBU_CTRL0_IDX, 8'hE2);
    t(16'h5656, 16'h0000, 1, 1, 1, 2'b01);
    t(16'h5656, 16'h0000, 1, 0, 0, 2'b00);
    $display("dual debug done");
    apb(1'b1, `HBU_CTRL0_IDX, 8'h01);
    t(16'h1234, 16'h0056, 1, 0, 0, 2'b00);
    apb(1'b1, `HBU_CTRL0_IDX, 8'h81);
    act <= 1'b1;
    t(16'h1234, 16'h5656, 1, 0, 0, 2'b00);
    act <= 1'b0;
    en <= 1'b0;
    t(16'h1234, 16'h5656, 1, 0, 0, 2'b00);
    $display("guards done");
    stop_test();
  end
endmodule
